// ===== src/lcd_shared_io_ports.sv
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
module lcd_shared_io_ports
   import lcd_port_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   input wire logic MCLK, // System clock, 40 MHz.
   input wire logic ARST_N, // Asynchronous reset, active low.
   input wire logic [ADDR_W-1:0] AVS_ADDRESS, // Word address (register index).
   input wire logic AVS_READ, // Read request.
   input wire logic AVS_WRITE, // Write request.
   input wire logic [3:0] AVS_BYTEENABLE, // Byte enables; lane 0 carries the data.
   input wire logic [31:0] AVS_WRITEDATA, // Write data.
   output logic [31:0] AVS_READDATA, // Read data.
   output logic AVS_WAITREQUEST, // Stall while the answer is prepared.
   input wire logic [2:0] OP_MODE, // Chip operating mode.
   input wire logic [PORT_W-1:0] LCD_SEG7, // Segment drive for port 7 pins.
   input wire logic [PORT_W-1:0] LCD_SEG8, // Segment drive for port 8 pins.
   input wire logic [PORT_W-1:0] PORT7_PIN_IN, // Port 7 pin levels.
   output logic [PORT_W-1:0] PORT7_PIN_OUT, // Port 7 pin drive values.
   output logic [PORT_W-1:0] PORT7_PIN_OE, // Port 7 drive enables.
   input wire logic [PORT_W-1:0] PORT8_PIN_IN, // Port 8 pin levels.
   output logic [PORT_W-1:0] PORT8_PIN_OUT, // Port 8 pin drive values.
   output logic [PORT_W-1:0] PORT8_PIN_OE // Port 8 drive enables.
);

   typedef struct packed {
      bus_state_t bus_st;
      logic [31:0] rdata;
      logic [3:0] pin_select;
      logic [PORT_W-1:0] p7_dir;
      logic [PORT_W-1:0] p7_data;
      logic [PORT_W-1:0] p8_dir;
      logic [PORT_W-1:0] p8_data;
      logic [PORT_W-1:0] p7_out;
      logic [PORT_W-1:0] p7_oe;
      logic [PORT_W-1:0] p8_out;
      logic [PORT_W-1:0] p8_oe;
   } port_state_t;

   port_state_t state_ff;
   port_state_t nxt_state;

   logic [2*PORT_W-1:0] pins_sync;
   logic [PORT_W-1:0] p7_level;
   logic [PORT_W-1:0] p8_level;
   logic [PORT_W-1:0] p7_gpio;
   logic [PORT_W-1:0] p8_gpio;
   logic bus_req;
   logic hit_cfg;
   logic hit_p7_data;
   logic hit_p8_data;
   logic hit_p7_dir;
   logic hit_p8_dir;
   logic mode_float;
   logic mode_hold;

   generate
      if (ADDR_W < 16) begin : g_bad_addr
         $error("ADDR_W must be at least 16 to reach the register indices");
      end
   endgenerate

   // Pin levels come from the board and are brought into the MCLK domain.
   pin_sync #(
      .WIDTH(2 * PORT_W)
   ) u_pin_sync (
      .clk(MCLK),
      .arst_n(ARST_N),
      .async_in({PORT8_PIN_IN, PORT7_PIN_IN}),
      .sync_out(pins_sync)
   );

   assign p7_level = pins_sync[PORT_W-1:0];
   assign p8_level = pins_sync[2*PORT_W-1:PORT_W];

   // True for each port 7 pin that the select field leaves as general I/O.
   function automatic logic [PORT_W-1:0] p7_gpio_mask(input logic [3:0] sel);
      logic hi_gpio;
      logic lo_gpio;
      hi_gpio = (sel[3:2] == 2'b00);
      lo_gpio = (sel[3:2] == 2'b00) || (sel == SEL_P7_LOW_LAST_GPIO);
      p7_gpio_mask = {{(PORT_W/2){hi_gpio}}, {(PORT_W/2){lo_gpio}}};
   endfunction : p7_gpio_mask

   // True for each port 8 pin that the select field leaves as general I/O.
   function automatic logic [PORT_W-1:0] p8_gpio_mask(input logic [3:0] sel);
      logic hi_gpio;
      logic lo_gpio;
      hi_gpio = (sel[3:1] == 3'b000);
      lo_gpio = (sel[3:1] == 3'b000) || (sel == SEL_P8_LOW_LAST_GPIO);
      p8_gpio_mask = {{(PORT_W/2){hi_gpio}}, {(PORT_W/2){lo_gpio}}};
   endfunction : p8_gpio_mask

   // Output pins read the latch, input pins read the synchronised pin level.
   function automatic logic [PORT_W-1:0] port_read(
      input logic [PORT_W-1:0] dir,
      input logic [PORT_W-1:0] latch,
      input logic [PORT_W-1:0] level
   );
      port_read = (dir & latch) | (~dir & level);
   endfunction : port_read

   // Writes land only in the bytes the master enables; lane 0 holds the 8-bit value.
   function automatic logic [PORT_W-1:0] lane0_write(
      input logic [PORT_W-1:0] old_value,
      input logic [3:0] be,
      input logic [31:0] wdata
   );
      lane0_write = be[0] ? wdata[PORT_W-1:0] : old_value;
   endfunction : lane0_write

   assign p7_gpio = p7_gpio_mask(state_ff.pin_select);
   assign p8_gpio = p8_gpio_mask(state_ff.pin_select);

   assign bus_req = AVS_READ | AVS_WRITE;

   always_comb begin
      hit_cfg = 1'b0;
      hit_p7_data = 1'b0;
      hit_p8_data = 1'b0;
      hit_p7_dir = 1'b0;
      hit_p8_dir = 1'b0;
      if (AVS_ADDRESS == ADDR_W'(IDX_LCD_PIN_CONFIG)) begin
         hit_cfg = 1'b1;
      end else if (AVS_ADDRESS == ADDR_W'(IDX_PORT7_DATA)) begin
         hit_p7_data = 1'b1;
      end else if (AVS_ADDRESS == ADDR_W'(IDX_PORT8_DATA)) begin
         hit_p8_data = 1'b1;
      end else if (AVS_ADDRESS == ADDR_W'(IDX_PORT7_DIR)) begin
         hit_p7_dir = 1'b1;
      end else if (AVS_ADDRESS == ADDR_W'(IDX_PORT8_DIR)) begin
         hit_p8_dir = 1'b1;
      end
   end

   // Reset itself floats the pins through the register reset value.
   always_comb begin
      mode_float = 1'b0;
      mode_hold = 1'b0;
      case (op_mode_t'(OP_MODE))
         MODE_STANDBY: begin
            mode_float = 1'b1;
         end
         MODE_SLEEP, MODE_SUBSLEEP, MODE_WATCH: begin
            mode_hold = 1'b1;
         end
         default: begin
            mode_hold = 1'b0;
         end
      endcase
   end

   always_comb begin
      nxt_state = state_ff;

      // One wait cycle: the answer is prepared, then handed over with waitrequest low.
      case (state_ff.bus_st)
         BUS_IDLE: begin
            if (bus_req) begin
               nxt_state.bus_st = BUS_ANSWER;
               nxt_state.rdata = UNMAPPED_READ_VALUE;
               if (hit_cfg) begin
                  nxt_state.rdata[SELECT_LSB +: SELECT_W] = state_ff.pin_select;
               end else if (hit_p7_data) begin
                  nxt_state.rdata[PORT_W-1:0] =
                     port_read(state_ff.p7_dir, state_ff.p7_data, p7_level);
               end else if (hit_p8_data) begin
                  nxt_state.rdata[PORT_W-1:0] =
                     port_read(state_ff.p8_dir, state_ff.p8_data, p8_level);
               end else if (hit_p7_dir) begin
                  nxt_state.rdata[PORT_W-1:0] = DIR_READ_VALUE;
               end else if (hit_p8_dir) begin
                  nxt_state.rdata[PORT_W-1:0] = DIR_READ_VALUE;
               end
            end
         end
         BUS_ANSWER: begin
            nxt_state.bus_st = BUS_IDLE;
            if (AVS_WRITE) begin
               if (hit_cfg) begin
                  if (AVS_BYTEENABLE[0]) begin
                     nxt_state.pin_select = AVS_WRITEDATA[SELECT_LSB +: SELECT_W];
                  end
               end else if (hit_p7_data) begin
                  nxt_state.p7_data =
                     lane0_write(state_ff.p7_data, AVS_BYTEENABLE, AVS_WRITEDATA);
               end else if (hit_p8_data) begin
                  nxt_state.p8_data =
                     lane0_write(state_ff.p8_data, AVS_BYTEENABLE, AVS_WRITEDATA);
               end else if (hit_p7_dir) begin
                  nxt_state.p7_dir =
                     lane0_write(state_ff.p7_dir, AVS_BYTEENABLE, AVS_WRITEDATA);
               end else if (hit_p8_dir) begin
                  nxt_state.p8_dir =
                     lane0_write(state_ff.p8_dir, AVS_BYTEENABLE, AVS_WRITEDATA);
               end
            end
         end
         default: begin
            nxt_state.bus_st = BUS_IDLE;
         end
      endcase

      // Pin drivers: floated in standby, frozen in the sleep family, live otherwise.
      if (mode_float) begin
         nxt_state.p7_oe = '0;
         nxt_state.p8_oe = '0;
      end else if (!mode_hold) begin
         // Segment pins always drive; I/O pins drive their latch when set as outputs.
         nxt_state.p7_oe = ~p7_gpio | state_ff.p7_dir;
         nxt_state.p7_out = (p7_gpio & state_ff.p7_data) | (~p7_gpio & LCD_SEG7);
         nxt_state.p8_oe = ~p8_gpio | state_ff.p8_dir;
         nxt_state.p8_out = (p8_gpio & state_ff.p8_data) | (~p8_gpio & LCD_SEG8);
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_ff.bus_st <= BUS_IDLE;
         state_ff.rdata <= UNMAPPED_READ_VALUE;
         state_ff.pin_select <= RST_PIN_SELECT;
         state_ff.p7_dir <= RST_PORT_DIR;
         state_ff.p7_data <= RST_PORT_DATA;
         state_ff.p8_dir <= RST_PORT_DIR;
         state_ff.p8_data <= RST_PORT_DATA;
         state_ff.p7_out <= RST_PORT_DATA;
         state_ff.p7_oe <= '0;
         state_ff.p8_out <= RST_PORT_DATA;
         state_ff.p8_oe <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign AVS_WAITREQUEST = bus_req & (state_ff.bus_st != BUS_ANSWER);
   assign AVS_READDATA = state_ff.rdata;
   assign PORT7_PIN_OUT = state_ff.p7_out;
   assign PORT7_PIN_OE = state_ff.p7_oe;
   assign PORT8_PIN_OUT = state_ff.p8_out;
   assign PORT8_PIN_OE = state_ff.p8_oe;

endmodule : lcd_shared_io_ports

// ===== src/lcd_port_pkg.sv
package lcd_port_pkg;

   // Register indices; the Avalon word address equals the index (byte address is four times it).
   localparam logic [15:0] IDX_LCD_PIN_CONFIG = 16'hFFC0;
   localparam logic [15:0] IDX_PORT7_DATA = 16'hFFDA;
   localparam logic [15:0] IDX_PORT8_DATA = 16'hFFDB;
   localparam logic [15:0] IDX_PORT7_DIR = 16'hFFEA;
   localparam logic [15:0] IDX_PORT8_DIR = 16'hFFEB;

   localparam logic [7:0] RST_PORT_DATA = 8'h00;
   localparam logic [7:0] RST_PORT_DIR = 8'h00;
   localparam logic [3:0] RST_PIN_SELECT = 4'h0;
   localparam logic [7:0] DIR_READ_VALUE = 8'hFF;
   localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h0000_0000;

   localparam int SELECT_LSB = 0;
   localparam int SELECT_W = 4;
   localparam int PORT_W = 8;
   localparam int SYNC_STAGES = 2;

   localparam logic [3:0] SEL_P7_LOW_LAST_GPIO = 4'h4;
   localparam logic [3:0] SEL_P8_LOW_LAST_GPIO = 4'h2;

   typedef enum logic [2:0] {
      MODE_ACTIVE = 3'h0,
      MODE_SUBACTIVE = 3'h1,
      MODE_SLEEP = 3'h2,
      MODE_SUBSLEEP = 3'h3,
      MODE_WATCH = 3'h4,
      MODE_STANDBY = 3'h5
   } op_mode_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'h0,
      BUS_ANSWER = 2'h1
   } bus_state_t;

endpackage : lcd_port_pkg

// ===== src/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
   import lcd_port_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input wire logic clk, // Sampling clock.
   input wire logic arst_n, // Asynchronous reset, active low.
   input wire logic [WIDTH-1:0] async_in, // Levels from outside the clock domain.
   output logic [WIDTH-1:0] sync_out // Levels after two flip-flops.
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_state_t;

   sync_state_t sync_ff;
   sync_state_t nxt_sync;

   generate
      if (WIDTH < 1) begin : g_bad_width
         $error("pin_sync width must be at least one");
      end
   endgenerate

   // Only the second stage reads the first one.
   always_comb begin
      nxt_sync.meta = async_in;
      nxt_sync.stable = sync_ff.meta;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync_ff <= '0;
      end else begin
         sync_ff <= nxt_sync;
      end
   end

   assign sync_out = sync_ff.stable;

endmodule : pin_sync

// ===== tb/lcd_port_sva.sv
`timescale 1ns/1ps
module lcd_port_sva
   import lcd_port_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   input wire logic MCLK, // Clock.
   input wire logic ARST_N, // Reset.
   input wire logic [ADDR_W-1:0] AVS_ADDRESS, // Address.
   input wire logic AVS_READ, // Read.
   input wire logic AVS_WRITE, // Write.
   input wire logic [3:0] AVS_BYTEENABLE, // Lanes.
   input wire logic [31:0] AVS_WRITEDATA, // Write data.
   input wire logic [31:0] AVS_READDATA, // Read data.
   input wire logic AVS_WAITREQUEST, // Stall.
   input wire logic [2:0] OP_MODE, // Mode.
   input wire logic [7:0] LCD_SEG7, // Segments 7.
   input wire logic [7:0] LCD_SEG8, // Segments 8.
   input wire logic [7:0] PORT7_PIN_IN, // Pins 7.
   input wire logic [7:0] PORT7_PIN_OUT, // Drive 7.
   input wire logic [7:0] PORT7_PIN_OE, // Enable 7.
   input wire logic [7:0] PORT8_PIN_IN, // Pins 8.
   input wire logic [7:0] PORT8_PIN_OUT, // Drive 8.
   input wire logic [7:0] PORT8_PIN_OE // Enable 8.
);
   typedef struct packed {
      logic [3:0] sel;
      logic [7:0] dir7;
      logic [7:0] dir8;
      logic [7:0] dat8;
   } shadow_t;
   shadow_t sh_ff;
   shadow_t nxt_sh;
   logic wr_ok;
   logic rd_ok;
   assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
   assign rd_ok = AVS_READ && !AVS_WAITREQUEST;
   // Shadow copies of the select, direction and port 8 data registers, updated at the edge a write completes.
   always_comb begin
      nxt_sh = sh_ff;
      if (wr_ok && AVS_ADDRESS == IDX_LCD_PIN_CONFIG) nxt_sh.sel = AVS_WRITEDATA[3:0];
      if (wr_ok && AVS_ADDRESS == IDX_PORT7_DIR) nxt_sh.dir7 = AVS_WRITEDATA[7:0];
      if (wr_ok && AVS_ADDRESS == IDX_PORT8_DIR) nxt_sh.dir8 = AVS_WRITEDATA[7:0];
      if (wr_ok && AVS_ADDRESS == IDX_PORT8_DATA) nxt_sh.dat8 = AVS_WRITEDATA[7:0];
   end
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) sh_ff <= '0;
      else sh_ff <= nxt_sh;
   end
   default clocking @(posedge MCLK); endclocking
   default disable iff (!ARST_N);
   a_reset_float: assert property (disable iff (1'b0) !ARST_N |->
      PORT7_PIN_OE == 8'h00 && PORT8_PIN_OE == 8'h00) else $error("pins driven in reset");
   a_wait_once: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
      |=> !AVS_WAITREQUEST) else $error("bus answer late");
   a_dir7_ones: assert property (rd_ok && AVS_ADDRESS == IDX_PORT7_DIR |->
      AVS_READDATA[7:0] == 8'hFF) else $error("port 7 direction read not ones");
   a_dir8_ones: assert property (rd_ok && AVS_ADDRESS == IDX_PORT8_DIR |->
      AVS_READDATA[7:0] == 8'hFF) else $error("port 8 direction read not ones");
   a_latch_back: assert property (rd_ok && AVS_ADDRESS == IDX_PORT8_DATA |->
      ((AVS_READDATA[7:0] ^ sh_ff.dat8) & sh_ff.dir8) == 8'h00) else $error("latch lost");
   a_p7_gpio: assert property (OP_MODE == 3'h0 && sh_ff.sel == 4'h0 |=>
      PORT7_PIN_OE == $past(sh_ff.dir7)) else $error("port 7 enable wrong");
   a_p8_gpio: assert property (OP_MODE inside {3'h0, 3'h1} && sh_ff.sel == 4'h0 |=>
      PORT8_PIN_OE == $past(sh_ff.dir8)) else $error("port 8 enable wrong");
   a_p7_split: assert property (OP_MODE == 3'h0 && sh_ff.sel == 4'h4 |=>
      PORT7_PIN_OE == {4'hF, $past(sh_ff.dir7[3:0])} &&
      PORT7_PIN_OUT[7:4] == $past(LCD_SEG7[7:4])) else $error("port 7 split wrong");
   a_p8_split: assert property (OP_MODE == 3'h0 && sh_ff.sel == 4'h2 |=>
      PORT8_PIN_OE == {4'hF, $past(sh_ff.dir8[3:0])} &&
      PORT8_PIN_OUT[7:4] == $past(LCD_SEG8[7:4])) else $error("port 8 split wrong");
   a_seg_all: assert property (OP_MODE == 3'h0 && sh_ff.sel[3] |=>
      {PORT7_PIN_OE, PORT8_PIN_OE} == 16'hFFFF && PORT7_PIN_OUT == $past(LCD_SEG7) &&
      PORT8_PIN_OUT == $past(LCD_SEG8)) else $error("segment drive wrong");
   a_standby_float: assert property (OP_MODE == 3'h5 |=>
      PORT7_PIN_OE == 8'h00 && PORT8_PIN_OE == 8'h00) else $error("standby pins driven");
   a_sleep_hold: assert property (OP_MODE inside {3'h2, 3'h3, 3'h4} |=>
      $stable({PORT7_PIN_OE, PORT7_PIN_OUT, PORT8_PIN_OE, PORT8_PIN_OUT}))
      else $error("pins moved while held");
   c_write: cover property (wr_ok);
   c_sleep: cover property (OP_MODE == 3'h2 ##1 OP_MODE == 3'h2);
   c_split: cover property (OP_MODE == 3'h0 && sh_ff.sel == 4'h4);
endmodule : lcd_port_sva
bind lcd_shared_io_ports lcd_port_sva #(.ADDR_W(ADDR_W)) i_sva (.*);

// ===== tb/pin_board.sv
`timescale 1ns/1ps
module pin_board (
   input wire logic [7:0] oe, // Device drive enables.
   input wire logic [7:0] drv, // Device drive values.
   input wire logic [7:0] ext, // Board drive where the device floats.
   output logic [7:0] lvl // Resulting pin levels.
);
   // A driven pin shows the device value, a floating one the board value.
   assign lvl = (oe & drv) | (~oe & ext);
endmodule : pin_board

// ===== tb/lcd_shared_io_ports_7_8_test.sv
`timescale 1ns/1ps
module lcd_shared_io_ports_7_8_test
   import lcd_port_pkg::*;
();
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [15:0] adr = 16'h0000;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [3:0] be = 4'hF;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic wait_q;
   logic [2:0] mode = 3'h0;
   logic [7:0] seg7 = 8'h00;
   logic [7:0] seg8 = 8'h00;
   logic [7:0] ext7 = 8'h00;
   logic [7:0] ext8 = 8'h00;
   logic [7:0] in7, out7, oe7, in8, out8, oe8;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;
   lcd_shared_io_ports i_dut (.MCLK(mclk), .ARST_N(arst_n), .AVS_ADDRESS(adr),
      .AVS_READ(rd), .AVS_WRITE(wr), .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wdat),
      .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_q), .OP_MODE(mode), .LCD_SEG7(seg7),
      .LCD_SEG8(seg8), .PORT7_PIN_IN(in7), .PORT7_PIN_OUT(out7), .PORT7_PIN_OE(oe7),
      .PORT8_PIN_IN(in8), .PORT8_PIN_OUT(out8), .PORT8_PIN_OE(oe8));
   pin_board i_b7 (.oe(oe7), .drv(out7), .ext(ext7), .lvl(in7));
   pin_board i_b8 (.oe(oe8), .drv(out8), .ext(ext8), .lvl(in8));
   always #12.5 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         results();
      end
   end
   task automatic results();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d,
      output logic [31:0] q);
      @(posedge mclk);
      adr <= a;
      wdat <= {24'h000000, d};
      rd <= !w;
      wr <= w;
      // Read right after the edge, waitrequest and read data still show their pre-edge values.
      do @(posedge mclk); while (wait_q !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic wr8(input logic [15:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr8
   // Expected {enable, drive masked by enable} for one port.
   function automatic logic [15:0] pin_ex(input logic hi, input logic lo,
      input logic [7:0] dir, input logic [7:0] dat, input logic [7:0] seg);
      logic [7:0] m;
      logic [7:0] oe;
      m = {{4{hi}}, {4{lo}}};
      oe = (dir & m) | ~m;
      pin_ex = {oe, ((dat & m) | (seg & ~m)) & oe};
   endfunction : pin_ex
   initial begin
      logic [31:0] q;
      logic [3:0] s;
      logic [7:0] d7, t7, d8, t8;
      logic [15:0] e7, e8;
      static logic [2:0] md [5] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h1};
      void'($urandom(32'h5FF5));
      repeat (16) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk);
      chk({16'h0, oe7, oe8}, 32'h0);
      bus(1'b0, IDX_PORT7_DIR, 8'h00, q);
      chk(q, 32'h0000_00FF);
      bus(1'b0, IDX_PORT8_DIR, 8'h00, q);
      chk(q, 32'h0000_00FF);
      bus(1'b0, 16'h1234, 8'h00, q);
      chk(q, 32'h0);
      wr8(IDX_PORT8_DIR, 8'hFF);
      bus(1'b0, IDX_PORT8_DATA, 8'h00, q);
      chk(q, 32'h0);
      be <= 4'h0;
      wr8(IDX_PORT8_DATA, 8'hA5);
      be <= 4'hF;
      bus(1'b0, IDX_PORT8_DATA, 8'h00, q);
      chk(q, 32'h0);
      $display("reset and access test done");
      for (int i = 0; i < 16; i++) begin
         s = i[3:0];
         d7 = 8'($urandom);
         t7 = 8'($urandom);
         d8 = 8'($urandom);
         t8 = 8'($urandom);
         seg7 <= 8'($urandom);
         seg8 <= 8'($urandom);
         ext7 <= 8'($urandom);
         ext8 <= 8'($urandom);
         mode <= i[0] ? 3'h1 : 3'h0;
         wr8(IDX_LCD_PIN_CONFIG, {4'h0, s});
         bus(1'b0, IDX_LCD_PIN_CONFIG, 8'h00, q);
         chk(q, {28'h0, s});
         wr8(IDX_PORT7_DIR, t7);
         wr8(IDX_PORT7_DATA, d7);
         wr8(IDX_PORT8_DIR, t8);
         wr8(IDX_PORT8_DATA, d8);
         repeat (3) @(posedge mclk);
         e7 = pin_ex(s[3:2] == 2'b00, s[3:2] == 2'b00 || s == 4'h4, t7, d7, seg7);
         e8 = pin_ex(s[3:1] == 3'b000, s[3:1] == 3'b000 || s == 4'h2, t8, d8, seg8);
         chk({16'h0, oe7, out7 & oe7}, {16'h0, e7});
         chk({16'h0, oe8, out8 & oe8}, {16'h0, e8});
         bus(1'b0, IDX_PORT7_DATA, 8'h00, q);
         chk(q, {24'h0, (d7 & t7) | ((e7[7:0] | (ext7 & ~e7[15:8])) & ~t7)});
         bus(1'b0, IDX_PORT8_DATA, 8'h00, q);
         chk(q, {24'h0, (d8 & t8) | ((e8[7:0] | (ext8 & ~e8[15:8])) & ~t8)});
      end
      $display("select and readback test done");
      wr8(IDX_LCD_PIN_CONFIG, 8'h04);
      foreach (md[k]) begin
         mode <= 3'h0;
         seg7 <= 8'($urandom);
         seg8 <= 8'($urandom);
         repeat (3) @(posedge mclk);
         mode <= md[k];
         @(posedge mclk);
         seg7 <= ~seg7;
         seg8 <= ~seg8;
         repeat (3) @(posedge mclk);
         e7 = pin_ex(1'b0, 1'b1, t7, d7, ~seg7);
         e8 = pin_ex(1'b0, 1'b0, t8, d8, ~seg8);
         if (md[k] == 3'h5) begin
            e7 = 16'h0;
            e8 = 16'h0;
         end else if (md[k] == 3'h1) begin
            e7 = pin_ex(1'b0, 1'b1, t7, d7, seg7);
            e8 = pin_ex(1'b0, 1'b0, t8, d8, seg8);
         end
         chk({oe7, out7 & oe7, oe8, out8 & oe8}, {e7, e8});
      end
      $display("operating mode test done");
      results();
   end
endmodule : lcd_shared_io_ports_7_8_test
